// ---- hw/dee_ctrl.v ----
// data eeprom access controller: ahb-lite slave, row latches, program timing,
// wait/halt handling, read-out protection and a maskable interrupt
// assumes one clock, ahb-lite single word transfers, option bit from outside
// limitation: hsize is not decoded, every access is taken as one word
//
// Contract
// - read mode returns stored bytes like rom
// - write mode captures writes in 32 latches
// - program start writes latched bytes to row
// - hardware times the programming cycle itself
// - program bit reads one while busy
// - latch bit cleared at end, guarded clear
// - latches cleared at end or latch falling
// - read in latch mode returns no data
// - write in read mode is ignored
// - wait entered after running cycle completes
// - halt aborts programming immediately
// - clearing program bit mid-cycle aborts it
// - protection blocks external read and rewrite
// - protection removal erases everything first
// - control register resets zero, upper bits zero
// - protection comes only from option bit
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"

module dee_ctrl #(
	parameter PROG_CYCLES = `DEE_PROG_CYCLES,
	parameter NCOLS       = 32
) (
	input  wire        clk_in,
	input  wire        resetn_in,
	input  wire        hsel_in,
	input  wire [11:0] haddr_in,
	input  wire [1:0]  htrans_in,
	input  wire        hwrite_in,
	input  wire [2:0]  hsize_in,
	input  wire [31:0] hwdata_in,
	input  wire        hready_in,
	output reg  [31:0] hrdata_out,
	output wire        hreadyout_out,
	output wire        hresp_out,
	input  wire        ext_access_in,
	input  wire        read_protect_option_in,
	input  wire        wait_for_interrupt_instr_in,
	input  wire        active_halt_in,
	input  wire        halt_instr_in,
	input  wire        wakeup_in,
	output wire        wait_state_out,
	output wire        halt_state_out,
	output reg         prog_mem_erase_out,
	output wire        irq_out
);
	// address phase capture
	reg        dp_valid_q;
	reg        dp_write_q;
	reg        dp_ext_q;
	reg [11:0] dp_addr_q;
	reg        rd_wait_q;
	// control/status and interrupt state
	reg        lat_q;
	reg        pgm_q;
	reg [2:0]  irq_stat_q;
	reg [2:0]  irq_mask_q;
	reg        wait_req_q;
	reg        halt_q;
	reg        rp_prev_q;
	reg        erase_q;
	// row latches
	reg [NCOLS*8-1:0] latch_data_q;
	reg [NCOLS-1:0]   latch_valid_q;
	reg [2:0]         row_q;

	wire       start;
	wire       abort;
	wire       busy;
	wire       done;
	wire [7:0] cell_rd;
	wire [7:0] byte_idx;
	// reset image of the control/status register
	localparam [7:0] CSR_RST = `DEE_CSR_RESET;

	// 1 when an address falls inside the eeprom window
	function in_area;
		input [11:0] a;
		begin
			in_area = (a >= `DEE_AREA_BASE) && (a <= `DEE_AREA_LAST);
		end
	endfunction

	// byte index of an eeprom window word address
	function [7:0] area_idx;
		input [11:0] a;
		begin
			area_idx = a[9:2];
		end
	endfunction

	// ahb-lite: okay always, one wait state on reads only
	assign hresp_out     = 1'b0;
	assign hreadyout_out = !rd_wait_q;
	assign byte_idx      = area_idx(dp_addr_q);

	// a read is served once, in its single wait cycle
	wire addr_phase = hsel_in && htrans_in[1] && hready_in;
	wire wr_phase   = dp_valid_q && dp_write_q;
	wire rd_phase   = dp_valid_q && !dp_write_q && rd_wait_q;
	// external access is locked out while the option bit protects
	wire locked     = read_protect_option_in && dp_ext_q;

	// data phase capture: a read holds hreadyout low for one cycle
	// so the cell array and control bits settle before hrdata
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_ext_q   <= 1'b0;
			dp_addr_q  <= 12'h000;
			rd_wait_q  <= 1'b0;
		end
		else
		begin
			if (hreadyout_out)
			begin
				dp_valid_q <= addr_phase;
				dp_write_q <= hwrite_in;
				dp_ext_q   <= ext_access_in;
				dp_addr_q  <= haddr_in;
				rd_wait_q  <= addr_phase && !hwrite_in;
			end
			else
			begin
				rd_wait_q  <= 1'b0;
				dp_valid_q <= 1'b0;
			end
		end
	end

	// register writes decoded in the write data phase
	// hwdata is only valid in the data phase, never decode it earlier
	wire csr_wr    = wr_phase && !locked && dp_addr_q == `DEE_CSR_OFS;
	wire stat_wr   = wr_phase && dp_addr_q == `DEE_IRQ_STAT_OFS;
	wire mask_wr   = wr_phase && dp_addr_q == `DEE_IRQ_MASK_OFS;
	wire area_wr   = wr_phase && in_area(dp_addr_q);
	wire area_rd   = rd_phase && in_area(dp_addr_q);
	wire new_pgm   = hwdata_in[`DEE_CSR_PGM_BIT];
	wire new_lat   = hwdata_in[`DEE_CSR_LAT_BIT];
	// latch write accepted only in write mode, idle, unlocked, not halted
	wire latch_wr  = area_wr && lat_q && !busy && !locked && !halt_q;
	// access error: area write in read mode or area read in write mode
	wire acc_err   = (area_wr && !lat_q) || (area_rd && lat_q);

	// start needs latch mode already set and no cycle running
	assign start = csr_wr && new_pgm && !pgm_q && lat_q && !halt_q;
	// abort on halt entry or software clearing the busy bit
	// protection erase stops the timer too, so no row lands
	// on a freshly wiped array
	assign abort = busy && (halt_instr_in || erase_q || (csr_wr && !new_pgm));

	// latch bit falls on software clear, end of cycle, or protection erase
	// a software clear is refused while the program bit stands
	wire lat_fall = lat_q && (done || erase_q || (csr_wr && !new_lat && !pgm_q));

	// control/status bits
	// end of cycle and abort win over a new start in the same cycle
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			lat_q <= CSR_RST[`DEE_CSR_LAT_BIT];
			pgm_q <= CSR_RST[`DEE_CSR_PGM_BIT];
		end
		else
		begin
			if (lat_fall)
				lat_q <= 1'b0;
			else if (csr_wr && new_lat)
				lat_q <= 1'b1;
			if (done || abort || erase_q)
				pgm_q <= 1'b0;
			else if (start)
				pgm_q <= 1'b1;
		end
	end

	// row latches: and-accumulate, cleared at end of cycle or latch fall
	// cleared bytes hold the erased value so a write and-accumulates
	genvar c;
	generate
		for (c = 0; c < NCOLS; c = c + 1)
		begin : g_latch
			always @(posedge clk_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					latch_data_q[c*8 +: 8] <= `DEE_ERASED_BYTE;
					latch_valid_q[c]       <= 1'b0;
				end
				else if (done || lat_fall)
				begin
					latch_data_q[c*8 +: 8] <= `DEE_ERASED_BYTE;
					latch_valid_q[c]       <= 1'b0;
				end
				else if (latch_wr && byte_idx[4:0] == c)
				begin
					latch_data_q[c*8 +: 8] <= latch_data_q[c*8 +: 8] & hwdata_in[7:0];
					latch_valid_q[c]       <= 1'b1;
				end
			end
		end
	endgenerate

	// row of the most recent latched write
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			row_q <= 3'h0;
		else if (latch_wr)
			row_q <= byte_idx[7:5];
	end

	// internal programming timer
	// 32-bit counter so any programming length fits
	dee_prog_timer #(
		.CYCLES (PROG_CYCLES),
		.W      (32)
	) u_timer (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.start_in  (start),
		.abort_in  (abort),
		.busy_out  (busy),
		.done_out  (done)
	);

	// cell array: row program at cycle end, full erase on protection removal
	// only columns written since the last clear are masked in
	dee_cells #(
		.ROWS (8),
		.COLS (NCOLS)
	) u_cells (
		.clk_in       (clk_in),
		.wr_en_in     (done),
		.wr_row_in    (row_q),
		.wr_mask_in   (latch_valid_q),
		.wr_data_in   (latch_data_q),
		.erase_all_in (erase_q),
		.rd_addr_in   (byte_idx),
		.rd_data_out  (cell_rd)
	);

	// option bit removal: one-cycle erase of eeprom and program memory
	// the program memory erase itself is done outside, on this strobe
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rp_prev_q          <= 1'b0;
			erase_q            <= 1'b0;
			prog_mem_erase_out <= 1'b0;
		end
		else
		begin
			rp_prev_q          <= read_protect_option_in;
			erase_q            <= rp_prev_q && !read_protect_option_in;
			prog_mem_erase_out <= rp_prev_q && !read_protect_option_in;
		end
	end

	// power saving: wait deferred while busy, halt immediate
	// a wait request taken during a cycle is held until busy falls
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wait_req_q <= 1'b0;
			halt_q     <= 1'b0;
		end
		else
		begin
			if (wakeup_in)
				wait_req_q <= 1'b0;
			else if (wait_for_interrupt_instr_in || active_halt_in)
				wait_req_q <= 1'b1;
			if (wakeup_in)
				halt_q <= 1'b0;
			else if (halt_instr_in)
				halt_q <= 1'b1;
		end
	end

	assign wait_state_out = wait_req_q && !busy;
	assign halt_state_out = halt_q;

	// sticky events: set wins over write-one-to-clear
	// bit 0 done, bit 1 access error, bit 2 aborted cycle
	wire [2:0] irq_set;
	assign irq_set[`DEE_IRQ_DONE_BIT]   = done;
	assign irq_set[`DEE_IRQ_ACCERR_BIT] = acc_err;
	assign irq_set[`DEE_IRQ_ABORT_BIT]  = abort;

	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			irq_stat_q <= `DEE_IRQ_RESET;
			irq_mask_q <= `DEE_IRQ_RESET;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~(stat_wr ? hwdata_in[2:0] : 3'h0)) | irq_set;
			if (mask_wr)
				irq_mask_q <= hwdata_in[2:0];
		end
	end

	assign irq_out = |(irq_stat_q & irq_mask_q);

	// read data registered in the read wait cycle
	// latched bytes never reach the bus: area reads in write mode give 0
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			hrdata_out <= 32'h0000_0000;
		else if (rd_phase)
		begin
			if (dp_addr_q == `DEE_CSR_OFS)
				hrdata_out <= {30'h0, lat_q, pgm_q | busy};
			else if (dp_addr_q == `DEE_IRQ_STAT_OFS)
				hrdata_out <= {29'h0, irq_stat_q};
			else if (dp_addr_q == `DEE_IRQ_MASK_OFS)
				hrdata_out <= {29'h0, irq_mask_q};
			else if (in_area(dp_addr_q) && !lat_q && !locked)
				hrdata_out <= {24'h00_0000, cell_rd};
			else
				hrdata_out <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ---- shared/dee_consts.vh ----
// data eeprom access controller: shared offsets, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef DEE_CONSTS_VH
`define DEE_CONSTS_VH

// register byte offsets on the ahb-lite slave
`define DEE_CSR_OFS        12'h020
`define DEE_IRQ_STAT_OFS   12'h024
`define DEE_IRQ_MASK_OFS   12'h028
// eeprom area: byte i sits in the low lane of word (base + 4*i)
`define DEE_AREA_BASE      12'h400
`define DEE_AREA_LAST      12'h7fc

// control/status fields
`define DEE_CSR_PGM_BIT    0
`define DEE_CSR_LAT_BIT    1
`define DEE_CSR_RESET      8'h00

// interrupt status fields
`define DEE_IRQ_DONE_BIT   0
`define DEE_IRQ_ACCERR_BIT 1
`define DEE_IRQ_ABORT_BIT  2
`define DEE_IRQ_RESET      3'h0

// programming cycle: time in ns and clock rate in mhz
`define DEE_PROG_TIME_NS   5000000
`define DEE_CLK_MHZ        250
`define DEE_PROG_CYCLES    ((`DEE_PROG_TIME_NS * `DEE_CLK_MHZ) / 1000)

// erased cell and cleared latch value
`define DEE_ERASED_BYTE    8'hff

`endif

// ---- hw/dee_cells.v ----
// data eeprom cell array: 256 bytes, one row-wide masked write port
// assumes writes and erase come from the controller on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"

module dee_cells #(
	parameter ROWS = 8,
	parameter COLS = 32
) (
	input  wire                 clk_in,
	input  wire                 wr_en_in,
	input  wire [2:0]           wr_row_in,
	input  wire [COLS-1:0]      wr_mask_in,
	input  wire [COLS*8-1:0]    wr_data_in,
	input  wire                 erase_all_in,
	input  wire [7:0]           rd_addr_in,
	output wire [7:0]           rd_data_out
);
	reg [7:0] mem [0:ROWS*COLS-1];
	integer   i;

	// cell content is not reset: it is non-volatile
	assign rd_data_out = mem[rd_addr_in];

	// full erase wins over a row program
	always @(posedge clk_in)
	begin
		for (i = 0; i < ROWS*COLS; i = i + 1)
		begin
			if (erase_all_in)
				mem[i] <= `DEE_ERASED_BYTE;
			else if (wr_en_in && wr_row_in == i[7:5] && wr_mask_in[i % COLS])
				mem[i] <= wr_data_in[(i % COLS)*8 +: 8];
		end
	end
endmodule
`default_nettype wire

// ---- hw/dee_prog_timer.v ----
// programming cycle timer: busy for exactly CYCLES clocks after a start
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none

module dee_prog_timer #(
	parameter CYCLES = 1250000,
	parameter W      = 21
) (
	input  wire clk_in,
	input  wire resetn_in,
	input  wire start_in,
	input  wire abort_in,
	output wire busy_out,
	output wire done_out
);
	reg [W-1:0] cnt_q;

	assign busy_out = (cnt_q != {W{1'b0}});
	assign done_out = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !abort_in;

	// loads the length, counts down to zero, abort stops at once
	always @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			cnt_q <= {W{1'b0}};
		else if (abort_in)
			cnt_q <= {W{1'b0}};
		else if (start_in)
			cnt_q <= CYCLES[W-1:0];
		else if (busy_out)
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end
endmodule
`default_nettype wire

// ---- verification/dee_cpu_model.sv ----
// ahb-lite master standing in for the cpu core
// assumes hready_in is the slave's hreadyout, one clock
`timescale 1ns/1ps
`default_nettype none
module dee_cpu_model (
	input  wire logic        clk_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_in,
	output logic             hsel_out,
	output logic [11:0]      haddr_out,
	output logic [1:0]       htrans_out,
	output logic [2:0]       hsize_out,
	output logic             hwrite_out,
	output logic [31:0]      hwdata_out,
	output logic             rd_valid_out,
	output logic [31:0]      rd_data_out,
	output logic             tmo_out
);
	initial {hsel_out, haddr_out, htrans_out, hsize_out, hwrite_out, hwdata_out,
		rd_valid_out, rd_data_out, tmo_out} = '0;
	// wake at the edge: inputs still show what stood there, our nbas follow it
	task automatic tick();
		@(posedge clk_in);
	endtask
	// hold until hready is seen high at an edge, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (hready_in !== 1'b1 && n < 64);
		if (hready_in !== 1'b1)
			tmo_out <= 1'b1;
	endtask
	// single word transfer; released address and data lines carry inverted values, hsel and htrans go idle
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
		hsel_out <= 1'b1;
		haddr_out <= a;
		htrans_out <= 2'h2;
		hsize_out <= 3'h2;
		hwrite_out <= w;
		wait_rdy();
		hsel_out <= 1'b0;
		htrans_out <= 2'h0;
		haddr_out <= ~a;
		hwdata_out <= w ? v : ~v;
		wait_rdy();
		hwdata_out <= ~v;
		rd_data_out <= hrdata_in;
		rd_valid_out <= !w;
		tick();
		rd_valid_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verification/dee_ctrl_asserts.sv ----
// port checker for the data eeprom controller
// assumes it is bound into dee_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"
module dee_ctrl_asserts (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic        hsel_in,
	input wire logic [11:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic        ext_access_in,
	input wire logic        read_protect_option_in,
	input wire logic        halt_instr_in,
	input wire logic        wakeup_in,
	input wire logic        wait_state_out,
	input wire logic        halt_state_out,
	input wire logic        prog_mem_erase_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// read taken in its address phase, then its one-wait data phase
	wire logic rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
	wire logic area = haddr_in[11:10] == 2'h1;
	sequence s_rd;
		rd_take;
	endsequence
	sequence s_rd_end;
		!hreadyout_out ##1 hreadyout_out;
	endsequence
	a_resp_okay: assert property (!hresp_out)
		else $error("response not okay");
	a_read_wait: assert property (s_rd |=> s_rd_end)
		else $error("read wait wrong");
	a_stall_cause: assert property (!hreadyout_out |-> $past(rd_take))
		else $error("stall without read");
	a_csr_upper: assert property (s_rd ##0 (haddr_in == `DEE_CSR_OFS) ##1 s_rd_end
		|-> hrdata_out[7:2] == 6'h0) else $error("csr upper bits set");
	a_protect_read: assert property (s_rd ##0 (area && ext_access_in && read_protect_option_in)
		##1 s_rd_end |-> hrdata_out == 32'h0) else $error("protected data read out");
	a_halt_enter: assert property (halt_instr_in && !wakeup_in |=> halt_state_out)
		else $error("halt not entered");
	a_wake_leave: assert property (wakeup_in && !halt_instr_in |=> !halt_state_out && !wait_state_out)
		else $error("wake did not leave");
	a_erase_pulse: assert property ($fell(read_protect_option_in) |-> ##[1:3] prog_mem_erase_out)
		else $error("no erase on unprotect");
	a_erase_once: assert property (prog_mem_erase_out |=> !prog_mem_erase_out)
		else $error("erase pulse too long");
	a_erase_cause: assert property (prog_mem_erase_out |-> !read_protect_option_in)
		else $error("erase while protected");
endmodule
bind dee_ctrl dee_ctrl_asserts u_chk (
	.clk_in                 (clk_in),
	.resetn_in              (resetn_in),
	.hsel_in                (hsel_in),
	.haddr_in               (haddr_in),
	.htrans_in              (htrans_in),
	.hwrite_in              (hwrite_in),
	.hready_in              (hready_in),
	.hrdata_out             (hrdata_out),
	.hreadyout_out          (hreadyout_out),
	.hresp_out              (hresp_out),
	.ext_access_in          (ext_access_in),
	.read_protect_option_in (read_protect_option_in),
	.halt_instr_in          (halt_instr_in),
	.wakeup_in              (wakeup_in),
	.wait_state_out         (wait_state_out),
	.halt_state_out         (halt_state_out),
	.prog_mem_erase_out     (prog_mem_erase_out)
);
`default_nettype wire

// ---- verification/dee_ctrl_tb.sv ----
// self-checking bench: map, programming, power modes, protection, interrupt
// assumes dee_cpu_model as bus master and a shortened programming count
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.vh"
module dee_ctrl_tb;
	localparam int          PC   = 20;
	localparam logic [11:0] CSR  = `DEE_CSR_OFS;
	localparam logic [11:0] STA  = `DEE_IRQ_STAT_OFS;
	localparam logic [11:0] MSK  = `DEE_IRQ_MASK_OFS;
	localparam logic [11:0] ROWA = `DEE_AREA_BASE + 12'h080;
	localparam logic [11:0] ROWB = `DEE_AREA_BASE + 12'h100;
	logic        clk_in = 1'b0;
	logic        resetn, hsel, hwrite, rdy, hresp, rdv, tmo, ext, prot;
	logic        wait_for_interrupt_instr, ahlt, hlt, wake, waitst, haltst, erase, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [11:0] haddr;
	logic [31:0] hwdata, hrdata, rdd;
	logic [31:0] exp_q[$];
	logic [7:0]  d[32];
	int          seed = 10;
	int          n_errors = 0;
	int          comparisons = 0;
	always #2 clk_in = ~clk_in;
	dee_ctrl #(.PROG_CYCLES(PC)) u_dut (.clk_in(clk_in), .resetn_in(resetn), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy),
		.hresp_out(hresp), .ext_access_in(ext), .read_protect_option_in(prot),
		.wait_for_interrupt_instr_in(wait_for_interrupt_instr), .active_halt_in(ahlt), .halt_instr_in(hlt),
		.wakeup_in(wake), .wait_state_out(waitst), .halt_state_out(haltst),
		.prog_mem_erase_out(erase), .irq_out(irq));
	dee_cpu_model u_mst (.clk_in(clk_in), .hready_in(rdy), .hrdata_in(hrdata),
		.hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
		.hsize_out(hsize), .hwdata_out(hwdata), .rd_valid_out(rdv), .rd_data_out(rdd),
		.tmo_out(tmo));
	task automatic tick();
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		u_mst.xfer(1'b1, a, v);
	endtask
	// note the expected value, then read
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_mst.xfer(1'b0, a, 32'h0);
	endtask
	task automatic chk(input string s, input logic e, input logic g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// each finished read against the oldest note
	always @(posedge clk_in)
	begin
		if (rdv === 1'b1)
		begin
			comparisons++;
			if (rdd !== exp_q[0])
			begin
				n_errors++;
				$display("[ERR] hrdata expected %h seen %h", exp_q[0], rdd);
			end
			void'(exp_q.pop_front());
		end
	end
	always @(posedge tmo)
	begin
		n_errors++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		{resetn, ext, prot, wait_for_interrupt_instr, ahlt, hlt, wake} = '0;
		repeat (12) @(posedge clk_in);
		resetn <= 1'b1;
		tick();
		rd(CSR, 32'h0);
		wr(CSR, 32'hfc);
		rd(CSR, 32'h0);
		rd(12'h100, 32'h0);
		prot <= 1'b1;
		tick();
		prot <= 1'b0;
		repeat (2) tick();
		chk("erase", 1'b1, erase);
		repeat (4) tick();
		rd(ROWA, 32'hff);
		wr(MSK, 32'h7);
		wr(ROWA, 32'h5a);
		rd(ROWA, 32'hff);
		chk("irq", 1'b1, irq);
		wr(MSK, 32'h0);
		chk("irq", 1'b0, irq);
		wr(STA, 32'h7);
		wr(MSK, 32'h7);
		chk("irq", 1'b0, irq);
		// fill one row, and-accumulate a second write into byte 0, program it
		wr(CSR, 32'h2);
		for (int i = 0; i < 32; i++)
		begin
			d[i] = 8'($random(seed));
			wr(ROWA + 12'(4 * i), 32'(d[i]) | 32'h5500);
		end
		wr(ROWA, 32'h0f);
		d[0] = d[0] & 8'h0f;
		rd(ROWA, 32'h0);
		wr(CSR, 32'h3);
		rd(CSR, 32'h3);
		wr(CSR, 32'h1);
		rd(CSR, 32'h3);
		repeat (PC) tick();
		rd(CSR, 32'h0);
		for (int i = 0; i < 32; i++)
			rd(ROWA + 12'(4 * i), 32'(d[i]));
		chk("irq", 1'b1, irq);
		wr(STA, 32'h7);
		// halt aborts a running cycle
		wr(CSR, 32'h2);
		wr(ROWB, 32'h3c);
		wr(CSR, 32'h3);
		hlt <= 1'b1;
		tick();
		hlt <= 1'b0;
		wake <= 1'b1;
		tick();
		wake <= 1'b0;
		rd(STA, 32'h4);
		// clearing the program bit mid-cycle aborts it
		wr(STA, 32'h7);
		wr(CSR, 32'h3);
		wr(CSR, 32'h2);
		rd(STA, 32'h4);
		// wait is entered only after the cycle ends
		wr(CSR, 32'h2);
		wr(ROWB, 32'h3c);
		wr(CSR, 32'h3);
		wait_for_interrupt_instr <= 1'b1;
		repeat (2) tick();
		chk("wait", 1'b0, waitst);
		repeat (PC) tick();
		chk("wait", 1'b1, waitst);
		wait_for_interrupt_instr <= 1'b0;
		ahlt <= 1'b1;
		tick();
		chk("wait", 1'b1, waitst);
		ahlt <= 1'b0;
		wake <= 1'b1;
		tick();
		wake <= 1'b0;
		rd(ROWB, 32'h3c);
		// protected external access, then removal erases
		prot <= 1'b1;
		ext <= 1'b1;
		rd(ROWB, 32'h0);
		wr(CSR, 32'h2);
		ext <= 1'b0;
		rd(CSR, 32'h0);
		prot <= 1'b0;
		repeat (6) tick();
		rd(ROWB, 32'hff);
		tick();
		if (exp_q.size() != 0)
		begin
			n_errors++;
			$display("[ERR] pending reads expected %0d seen %0d", 0, exp_q.size());
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
